// [hdl/gwwe_map.vh]
// Constants of the window write engine: fields, reset values, codes
`ifndef GWWE_MAP_VH
`define GWWE_MAP_VH

// ------------------------------------------------------------
// APB register offsets
// ------------------------------------------------------------
`define GWWE_OFF_HWIN      12'h000
`define GWWE_OFF_VWIN      12'h004
`define GWWE_OFF_ENTRY     12'h008
`define GWWE_OFF_MASK      12'h00C
`define GWWE_OFF_CMP       12'h010
`define GWWE_OFF_PTR       12'h014
`define GWWE_OFF_STAT      12'h018
`define GWWE_OFF_LAST      12'h01C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define GWWE_START_LSB     0
`define GWWE_END_LSB       8
`define GWWE_ENT_HSIGN     0
`define GWWE_ENT_VSIGN     1
`define GWWE_ENT_VERT      2
`define GWWE_ENT_LOP_LSB   4
`define GWWE_ENT_BURST     8
`define GWWE_ENT_WIN       9

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define GWWE_HWIN_RST      16'h8300
`define GWWE_VWIN_RST      16'hAF00
`define GWWE_ENTRY_RST     10'h003
`define GWWE_MASK_RST      18'h00000
`define GWWE_CMP_RST       16'h0000
`define GWWE_PTR_RST       16'h0000
`define GWWE_LAST_RST      18'h00000
`define GWWE_H_MAX         8'h83
`define GWWE_V_MAX         8'hAF

// ------------------------------------------------------------
// Logic operation codes and burst word count
// ------------------------------------------------------------
`define GWWE_LOP_REPLACE   3'h0
`define GWWE_LOP_CMP_EQ    3'h6
`define GWWE_LOP_CMP_NE    3'h7
`define GWWE_BURST_WORDS   3'h4

`endif

// [hdl/gwwe_mem.v]
// Display memory array, one 18-bit word per address
`timescale 1ns/100ps
module gwwe_mem (
  input  wire        clk_sys,
  input  wire        we,
  input  wire [15:0] waddr,
  input  wire [17:0] wdata,
  input  wire [15:0] raddr,
  output reg  [17:0] rdata
);
  reg [17:0] mem [0:65535];

  always @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [hdl/gwwe_step.v]
// Pointer stepping inside window bounds for one axis
`timescale 1ns/100ps
module gwwe_step (
  input  wire [7:0] pos,
  input  wire [7:0] lo,
  input  wire [7:0] hi,
  input  wire       up,
  output wire [7:0] nxt,
  output wire       wrap
);
  assign wrap = up ? (pos >= hi) : (pos <= lo);
  assign nxt  = wrap ? (up ? lo : hi) :
                (up ? pos + 8'h01 : pos - 8'h01);
endmodule

// [hdl/gwwe_top.v]
// Window write engine: pointer, mask, compare and memory write path
//
// Functional notes
// - Writes fill consecutive locations inside the four 8-bit window bounds.
// - Pointer advances per direction select (always horizontal in burst mode) and step signs automatically.
// - Mask bit 0 writes data bit; mask bit 1 keeps stored bit.
// - 16-bit and 8-bit host data expanded to 18 bits first.
// - Horizontal replace: step by one, jump to next row at edge.
// - Vertical replace: step 256, at row edge wrap per sign and step column.
// - Horizontal compare-conditioned masked write, bytewise against pattern.
// - Vertical compare-conditioned masked write; pointer steps vertically at take, before the write.
// - Burst mode disables logical and compare operations.
`timescale 1ns/100ps
`include "gwwe_map.vh"
module gwwe_top (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        pix_valid,
  input  wire [17:0] pix_data,
  input  wire [1:0]  pix_width,
  output wire        pix_ready
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [15:0] hwin_r;
  reg  [15:0] vwin_r;
  reg  [9:0]  entry_r;
  reg  [17:0] mask_r;
  reg  [15:0] cmp_r;
  reg  [15:0] ptr_r;
  reg  [15:0] ptr_nxt;
  reg  [31:0] wr_count_r;
  reg  [17:0] last_r;

  wire [7:0] h_lo = hwin_r[`GWWE_START_LSB +: 8];
  wire [7:0] h_hi = hwin_r[`GWWE_END_LSB +: 8];
  wire [7:0] v_lo = vwin_r[`GWWE_START_LSB +: 8];
  wire [7:0] v_hi = vwin_r[`GWWE_END_LSB +: 8];
  wire       hsign    = entry_r[`GWWE_ENT_HSIGN];
  wire       vsign    = entry_r[`GWWE_ENT_VSIGN];
  wire       vert_sel = entry_r[`GWWE_ENT_VERT];
  wire [2:0] lop      = entry_r[`GWWE_ENT_LOP_LSB +: 3];
  wire       burst_md = entry_r[`GWWE_ENT_BURST];
  wire       win  = entry_r[`GWWE_ENT_WIN];

  // ------------------------------------------------------------
  // Pipeline states
  // ------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_READ  = 3'b010;
  localparam ST_WRITE = 3'b100;
  reg  [2:0]  state_r;
  reg  [17:0] data_r;
  reg  [15:0] waddr_r;

  // Burst mode collects four words before committing
  reg  [17:0] bq_data_r [0:3];
  reg  [15:0] bq_addr_r [0:3];
  reg  [2:0]  bq_cnt_r;
  reg  [2:0]  bq_out_r;

  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign pix_ready = (state_r == ST_IDLE) && (bq_out_r == 3'h0);

  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !penable && !pwrite;
  wire take   = pix_valid && pix_ready;
  wire ptr_wr = apb_wr && (paddr == `GWWE_OFF_PTR);

  // ------------------------------------------------------------
  // Host data expansion
  // ------------------------------------------------------------
  reg [17:0] pix18;
  always @* begin
    case (pix_width)
      2'h1:    pix18 = {pix_data[15:11], pix_data[15], pix_data[10:0],
                        pix_data[4]};
      2'h2:    pix18 = {pix_data[7:2], pix_data[7:2], pix_data[7:2]};
      default: pix18 = pix_data;
    endcase
  end

  // ------------------------------------------------------------
  // Pointer stepping
  // ------------------------------------------------------------
  wire [7:0] col = ptr_r[7:0];
  wire [7:0] row = ptr_r[15:8];
  wire [7:0] h_lo_e = win ? h_lo : 8'h00;
  wire [7:0] h_hi_e = win ? h_hi : `GWWE_H_MAX;
  wire [7:0] v_lo_e = win ? v_lo : 8'h00;
  wire [7:0] v_hi_e = win ? v_hi : `GWWE_V_MAX;
  wire [7:0] col_n;
  wire [7:0] row_n;
  wire       col_w;
  wire       row_w;

  gwwe_step u_col (
    .pos  (col),
    .lo   (h_lo_e),
    .hi   (h_hi_e),
    .up   (hsign),
    .nxt  (col_n),
    .wrap (col_w)
  );

  gwwe_step u_row (
    .pos  (row),
    .lo   (v_lo_e),
    .hi   (v_hi_e),
    .up   (vsign),
    .nxt  (row_n),
    .wrap (row_w)
  );

  always @* begin
    ptr_nxt = ptr_r;
    if (!vert_sel || burst_md) begin
      ptr_nxt[7:0] = col_n;
      if (col_w) begin
        ptr_nxt[15:8] = row_n;
      end
    end else begin
      ptr_nxt[15:8] = row_n;
      if (row_w) begin
        ptr_nxt[7:0] = col_n;
      end
    end
  end

  // ------------------------------------------------------------
  // Compare condition
  // ------------------------------------------------------------
  wire [17:0] rd_data;
  wire [7:0]  d_hi = {data_r[17:13], data_r[11:9]};
  wire [7:0]  d_lo = {data_r[8:6], data_r[5:1]};
  wire        eq_b = (d_hi == cmp_r[15:8]) && (d_lo == cmp_r[7:0]);
  reg         cond;
  always @* begin
    case (lop)
      `GWWE_LOP_CMP_EQ: cond = eq_b;
      `GWWE_LOP_CMP_NE: cond = !eq_b;
      default:         cond = 1'b1;
    endcase
  end

  wire [17:0] merged = (data_r & ~mask_r) | (rd_data & mask_r);
  wire [17:0] bq_mg  = (bq_data_r[bq_out_r[1:0]] & ~mask_r) |
                       (rd_data & mask_r);

  wire        mem_we    = (state_r == ST_WRITE) && cond;
  wire        burst_we  = (bq_out_r != 3'h0) && (state_r == ST_WRITE);
  wire [15:0] mem_waddr = burst_md ? bq_addr_r[bq_out_r[1:0]] : waddr_r;
  wire [17:0] mem_wdata = burst_md ? bq_mg : merged;
  wire [15:0] mem_raddr = burst_md ? bq_addr_r[bq_out_r[1:0]] : waddr_r;
  wire        mem_wen   = burst_md ? burst_we : mem_we;

  gwwe_mem u_mem (
    .clk_sys (clk_sys),
    .we      (mem_wen),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (rd_data)
  );

  // ------------------------------------------------------------
  // Write sequencing
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      data_r     <= 18'h00000;
      waddr_r    <= 16'h0000;
      ptr_r      <= `GWWE_PTR_RST;
      bq_cnt_r   <= 3'h0;
      bq_out_r   <= 3'h0;
      wr_count_r <= 32'h00000000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take && burst_md) begin
            bq_data_r[bq_cnt_r[1:0]] <= pix18;
            bq_addr_r[bq_cnt_r[1:0]] <= ptr_r;
            ptr_r <= ptr_nxt;
            if (bq_cnt_r == `GWWE_BURST_WORDS - 3'h1) begin
              bq_cnt_r <= 3'h0;
              bq_out_r <= 3'h4;
              state_r  <= ST_READ;
            end else begin
              bq_cnt_r <= bq_cnt_r + 3'h1;
            end
          end else if (take) begin
            data_r  <= pix18;
            waddr_r <= ptr_r;
            ptr_r   <= ptr_nxt;
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          state_r <= ST_WRITE;
        end
        ST_WRITE: begin
          if (burst_md && bq_out_r != 3'h0) begin
            wr_count_r <= wr_count_r + 32'h00000001;
            if (bq_out_r == 3'h1) begin
              bq_out_r <= 3'h0;
              state_r  <= ST_IDLE;
            end else begin
              bq_out_r <= bq_out_r - 3'h1;
              state_r  <= ST_READ;
            end
          end else begin
            if (cond) begin
              wr_count_r <= wr_count_r + 32'h00000001;
            end
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // Pointer load taken in every state, so no bus write is lost
      if (ptr_wr) begin
        ptr_r    <= pwdata[15:0];
        bq_cnt_r <= 3'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // APB register file
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      hwin_r  <= `GWWE_HWIN_RST;
      vwin_r  <= `GWWE_VWIN_RST;
      entry_r <= `GWWE_ENTRY_RST;
      mask_r  <= `GWWE_MASK_RST;
      cmp_r   <= `GWWE_CMP_RST;
    end else if (apb_wr) begin
      case (paddr)
        `GWWE_OFF_HWIN:  hwin_r  <= pwdata[15:0];
        `GWWE_OFF_VWIN:  vwin_r  <= pwdata[15:0];
        `GWWE_OFF_ENTRY: entry_r <= pwdata[9:0];
        `GWWE_OFF_MASK:  mask_r  <= pwdata[17:0];
        `GWWE_OFF_CMP:   cmp_r   <= pwdata[15:0];
        default:         hwin_r  <= hwin_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Last committed word
  // ------------------------------------------------------------
  // Memory has no bus read path, so the last write is shown here
  always @(posedge clk_sys) begin
    if (rst) begin
      last_r <= `GWWE_LAST_RST;
    end else if (mem_wen) begin
      last_r <= mem_wdata;
    end
  end

  // Read data captured in setup so it stands for the access phase
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      case (paddr)
        `GWWE_OFF_HWIN:  prdata <= {16'h0000, hwin_r};
        `GWWE_OFF_VWIN:  prdata <= {16'h0000, vwin_r};
        `GWWE_OFF_ENTRY: prdata <= {22'h000000, entry_r};
        `GWWE_OFF_MASK:  prdata <= {14'h0000, mask_r};
        `GWWE_OFF_CMP:   prdata <= {16'h0000, cmp_r};
        `GWWE_OFF_PTR:   prdata <= {16'h0000, ptr_r};
        `GWWE_OFF_STAT:  prdata <= wr_count_r;
        `GWWE_OFF_LAST:  prdata <= {14'h0000, last_r};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// [tb/gwwe_top_properties.sv]
// Port checker of the window write engine
`timescale 1ns/100ps
module gwwe_top_chk (
  input wire        clk_sys,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        pix_valid,
  input wire [17:0] pix_data,
  input wire [1:0]  pix_width,
  input wire        pix_ready
);
  wire       wa = psel && penable && pwrite;
  wire       rs = psel && !penable && !pwrite;
  wire       tk = pix_valid && pix_ready;
  reg [15:0] pt_r;
  reg        ok_r;
  reg        burst_r;
  // Pointer copy trusted only until a pixel or other write may move it
  always @(posedge clk_sys) begin
    if (rst) begin
      pt_r <= 16'h0000;
      ok_r <= 1'h1;
      burst_r <= 1'h0;
    end else begin
      if (wa && paddr == 12'h008) burst_r <= pwdata[8];
      if (wa && paddr == 12'h014) pt_r <= pwdata[15:0];
      ok_r <= (wa && paddr == 12'h014) || (ok_r && !wa && !tk);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; !pslverr; endproperty
  a_err: assert property (p_err) else $error("pslverr high");
  // Reset itself is the cause here, so no disable
  property p_rst;
    disable iff (1'h0) rst |=> pix_ready && prdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_umap; rs && paddr > 12'h01C |=> prdata == 32'h0; endproperty
  a_umap: assert property (p_umap) else $error("unmapped read");
  property p_ptr;
    rs && paddr == 12'h014 && ok_r |=> prdata == {16'h0000, pt_r};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer readback");
  property p_busy;
    tk && !burst_r |=> !pix_ready [*2] ##1 pix_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length");
  property p_fell; $fell(pix_ready) |-> $past(tk); endproperty
  a_fell: assert property (p_fell) else $error("busy without take");
  property p_idle; (!tk && !burst_r) [*3] |-> pix_ready; endproperty
  a_idle: assert property (p_idle) else $error("stuck busy");
  cover property (tk && !burst_r);
  cover property (tk && burst_r);
  cover property (rs && paddr == 12'h014 && ok_r);
  cover property (rs && paddr > 12'h01C);
endmodule
bind gwwe_top gwwe_top_chk gwwe_top_chk_i (.clk_sys, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pix_valid,
  .pix_data, .pix_width, .pix_ready);

// [tb/gwwe_host.sv]
// Host model streaming pixel words over valid/ready
`timescale 1ns/100ps
module gwwe_host (
  input  wire        clk_sys,
  input  wire        go,
  input  wire        slow,
  input  wire [7:0]  n,
  input  wire [17:0] word,
  input  wire [1:0]  wid,
  output reg         pix_valid = 1'h0,
  output reg  [17:0] pix_data = 18'h0,
  output reg  [1:0]  pix_width = 2'h0,
  input  wire        pix_ready,
  output wire        busy
);
  reg  [7:0] left_r = 8'h0;
  wire       tk = pix_valid && pix_ready;
  wire       v_nxt = go || (busy && !(tk && (left_r == 8'h1 || slow)));
  assign busy = left_r != 8'h0;
  // Word held until taken; idle bus shows inverted data, not stale
  always @(posedge clk_sys) begin
    if (go)
      left_r <= n;
    else if (tk)
      left_r <= left_r - 8'h1;
    pix_valid <= v_nxt;
    pix_width <= wid;
    pix_data <= v_nxt ? word : ~pix_data;
  end
endmodule

// [tb/display_memory_window_write_engine_tb.sv]
// Bench of the window write engine: registers and pointer stepping
`timescale 1ns/100ps
module display_memory_window_write_engine_tb;
  localparam [11:0] a_ptr = 12'h014;
  localparam [11:0] a_st = 12'h018;
  localparam [11:0] a_lw = 12'h01C;
  reg  [1:0]  wid = 2'h0;
  reg         clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  reg         pwrite = 1'h0, go = 1'h0, slow = 1'h0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0, q;
  reg  [17:0] word = 18'h0;
  reg  [7:0]  n_px = 8'h0;
  wire [31:0] prdata;
  wire [17:0] pix_data;
  wire [1:0]  pix_width;
  wire        pready, pslverr, pix_valid, pix_ready, busy;
  integer     n_fail = 0, checks_done = 0, cyc = 0;
  gwwe_top gwwe_top_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pix_valid, .pix_data, .pix_width,
    .pix_ready);
  gwwe_host gwwe_host_i (.clk_sys, .go, .slow, .n(n_px), .word, .wid,
    .pix_valid, .pix_data, .pix_width, .pix_ready, .busy);
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task results;
    begin
      $display("compares %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Request held until pready seen high at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      q = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      apb(1'h0, a, 32'h0);
      chk(q, e);
    end
  endtask
  // Stream n words, let the memory write land, then read back
  task run(input [7:0] n, input [17:0] w, input [11:0] a, input [31:0] e);
    begin
      go <= 1'h1;
      n_px <= n;
      word <= w;
      @(posedge clk_sys);
      go <= 1'h0;
      do @(negedge clk_sys); while (busy);
      // Ready again only once the last memory write has landed
      do @(negedge clk_sys); while (!pix_ready);
      @(posedge clk_sys);
      rd(a, e);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rd(12'h000, 32'h8300);
    rd(12'h004, 32'hAF00);
    rd(12'h008, 32'h3);
    rd(12'h00C, 32'h0);
    rd(12'h010, 32'h0);
    rd(a_ptr, 32'h0);
    rd(a_lw, 32'h0);
    apb(1'h1, 12'h020, 32'hFFFFFFFF);
    rd(12'h020, 32'h0);
    apb(1'h1, 12'h000, 32'h1210);
    apb(1'h1, 12'h004, 32'h2120);
    apb(1'h1, 12'h008, 32'h203);
    rd(12'h000, 32'h1210);
    apb(1'h1, a_ptr, 32'h2010);
    run(8'h3, 18'h0, a_ptr, 32'h2110);
    run(8'h3, 18'h0, a_ptr, 32'h2010);
    apb(1'h1, 12'h008, 32'h207);
    apb(1'h1, a_ptr, 32'h2010);
    run(8'h2, 18'h0, a_ptr, 32'h2011);
    slow <= 1'h1;
    run(8'h4, 18'h0, a_ptr, 32'h2010);
    slow <= 1'h0;
    apb(1'h1, 12'h008, 32'h202);
    apb(1'h1, a_ptr, 32'h2010);
    run(8'h1, 18'h0, a_ptr, 32'h2112);
    rd(a_st, 32'hD);
    apb(1'h1, 12'h008, 32'h63);
    run(8'h1, 18'h0, a_st, 32'hE);
    run(8'h1, 18'h3FFFF, a_st, 32'hE);
    apb(1'h1, 12'h008, 32'h77);
    run(8'h1, 18'h0, a_st, 32'hE);
    run(8'h1, 18'h3FFFF, a_st, 32'hF);
    apb(1'h1, 12'h008, 32'h3);
    apb(1'h1, a_ptr, 32'h0);
    run(8'h1, 18'h3FFFF, a_lw, 32'h3FFFF);
    apb(1'h1, 12'h00C, 32'hF0F0);
    apb(1'h1, a_ptr, 32'h0);
    run(8'h1, 18'h0, a_lw, 32'hF0F0);
    apb(1'h1, 12'h00C, 32'h0);
    wid <= 2'h1;
    run(8'h1, 18'hF81F, a_lw, 32'h3F03F);
    wid <= 2'h2;
    run(8'h1, 18'h84, a_lw, 32'h21861);
    wid <= 2'h0;
    rd(a_st, 32'h13);
    apb(1'h1, 12'h000, 32'h1310);
    apb(1'h1, 12'h008, 32'h363);
    apb(1'h1, a_ptr, 32'h2010);
    run(8'h4, 18'h3FFFF, a_ptr, 32'h2110);
    rd(a_st, 32'h17);
    rd(a_lw, 32'h3FFFF);
    results;
  end
endmodule
